/* File: logic/tic_channel.sv */
`timescale 1ns/1ps
`include "tic_cfg.svh"
module tic_channel
   import tic_pkg::*;
#(
   parameter int CHANNEL = 0,
   parameter int ADDR_W  = 8,
   parameter int CNT_W   = 16
) (
   // clock and reset
   input  wire logic              SYS_CLK,
   input  wire logic              RST_N,
   // apb slave
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [31:0]       PWDATA,
   input  wire logic [3:0]        PSTRB,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // prescaler clock enables, one-cycle pulses
   input  wire logic [3:0]        PRESCALER_CLK_EN,
   // timer pins and events
   input  wire logic              TIMER_INPUT_PIN,
   output logic                   TIMER_OUTPUT_PIN,
   output logic                   CHANNEL_INTERRUPT,
   output logic                   INPUT_EDGE
);

   // ----------------------------------------
   // channel-dependent write masks
   // ----------------------------------------
   localparam bit HAS_B11 = (CHANNEL == 1) || (CHANNEL == 2) ||
                            (CHANNEL == 3) || (CHANNEL == 6);
   localparam bit HAS_CK23 = (CHANNEL == 1) || (CHANNEL == 3);
   localparam bit IS_SPLIT = HAS_CK23;
   localparam logic [15:0] B11_M  = 16'h0001 << `TIC_MODE_SPLIT;
   localparam logic [15:0] CK23_M = 16'h0001 << `TIC_MODE_CKS_LO;
   localparam logic [15:0] MODE_M = `TIC_MODE_WMASK
      & (HAS_B11 ? 16'hFFFF : ~B11_M)
      & (HAS_CK23 ? 16'hFFFF : ~CK23_M);

   function automatic logic [15:0] lane_mask(input logic [3:0] s);
      lane_mask = {{8{s[1]}}, {8{s[0]}}};
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [15:0]      mode_r;
   logic [CNT_W-1:0] period_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   tic_state_t       state_r;
   tic_state_t       state_nxt;
   logic             out_r;
   logic             out_nxt;
   logic             oe_r;
   logic             nfen_r;
   logic             irq_r;
   logic             evt;
   logic             pready_r;
   logic             pslverr_r;
   logic [31:0]      prdata_r;

   // ----------------------------------------
   // mode field decode
   // ----------------------------------------
   wire tic_cks_t  cks  = tic_cks_t'(
      mode_r[`TIC_MODE_CKS_HI:`TIC_MODE_CKS_LO]);
   wire tic_edge_t cis  = tic_edge_t'(
      mode_r[`TIC_MODE_CIS_HI:`TIC_MODE_CIS_LO]);
   wire tic_opm_t  opm  = tic_opm_t'(
      mode_r[`TIC_MODE_OPM_HI:`TIC_MODE_OPM_LO]);
   wire tic_sts_t  sts  = tic_sts_t'(
      mode_r[`TIC_MODE_STS_HI:`TIC_MODE_STS_LO]);
   wire ccs      = mode_r[`TIC_MODE_CCS];
   wire md0      = mode_r[`TIC_MODE_MD0];
   wire split    = IS_SPLIT && mode_r[`TIC_MODE_SPLIT];
   wire interval = (opm == TIC_OPM_INTERVAL);
   wire soft_st  = (sts == TIC_STS_SOFT);
   // input counts as used once any source bit is set
   wire in_used  = ccs | (sts != TIC_STS_SOFT);

   // ----------------------------------------
   // operating clock select
   // ----------------------------------------
   wire fmck = (cks == TIC_CK0) ? PRESCALER_CLK_EN[0] :
               (cks == TIC_CK1) ? PRESCALER_CLK_EN[1] :
               (cks == TIC_CK2) ? PRESCALER_CLK_EN[2] :
                                  PRESCALER_CLK_EN[3];

   // ----------------------------------------
   // input conditioning
   // ----------------------------------------
   logic [2:0] sync_r;
   logic       sync_lvl_r;
   logic       smp_r;
   logic       in_lvl_r;
   logic       edge_r;

   // the filter is clocked only while the input is in use; the
   // start-up waits in software cover the refill after enabling
   wire filt_clk = fmck & in_used;
   wire filt_ok  = ~nfen_r | (smp_r == sync_lvl_r);
   wire in_nxt   = (filt_clk & filt_ok) ? sync_lvl_r : in_lvl_r;
   wire rise     = in_nxt & ~in_lvl_r;
   wire fall     = ~in_nxt & in_lvl_r;
   wire edge_nxt = (cis == TIC_EDGE_FALL) ? fall :
                   (cis == TIC_EDGE_RISE) ? rise : (rise | fall);

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sync_r     <= 3'h0;
         sync_lvl_r <= 1'b0;
      end else begin
         sync_r <= {sync_r[1:0], TIMER_INPUT_PIN};
         if (sync_r[1] == sync_r[2]) begin
            sync_lvl_r <= sync_r[2];
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         smp_r    <= 1'b0;
         in_lvl_r <= 1'b0;
         edge_r   <= 1'b0;
      end else begin
         if (filt_clk) begin
            smp_r <= sync_lvl_r;
         end
         in_lvl_r <= in_nxt;
         edge_r   <= edge_nxt;
      end
   end

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire [7:0] ofs = 8'(PADDR);
   wire sel_mode = (ofs == `TIC_OFS_MODE);
   wire sel_per  = (ofs == `TIC_OFS_PERIOD);
   wire sel_cnt  = (ofs == `TIC_OFS_COUNT);
   wire sel_st   = (ofs == `TIC_OFS_START);
   wire sel_lvl  = (ofs == `TIC_OFS_OUTLVL);
   wire sel_oe   = (ofs == `TIC_OFS_OUTEN);
   wire sel_nf   = (ofs == `TIC_OFS_NFEN);
   wire hit      = sel_mode | sel_per | sel_cnt | sel_st |
                   sel_lvl | sel_oe | sel_nf;
   wire setup    = PSEL & ~PENABLE;
   wire wr       = PSEL & PENABLE & pready_r & PWRITE & hit;
   wire [15:0] lm = lane_mask(PSTRB);
   wire start_wr = wr & sel_st & PSTRB[0] & PWDATA[`TIC_START_BIT];
   wire stop_wr  = wr & sel_st & PSTRB[0] & PWDATA[`TIC_STOP_BIT];
   wire lvl_wr   = wr & sel_lvl & PSTRB[0];
   wire running  = (state_r != TIC_IDLE);

   wire [31:0] rd_data =
      sel_mode ? {16'h0000, mode_r} :
      sel_per  ? 32'(period_r) :
      sel_cnt  ? 32'(cnt_r) :
      sel_st   ? 32'(running) :
      sel_lvl  ? 32'(out_r) :
      sel_oe   ? 32'(oe_r) :
      sel_nf   ? 32'(nfen_r) : 32'h0000_0000;

   // zero wait states: ready is raised in the first access cycle
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= setup;
         pslverr_r <= setup & ~hit;
         prdata_r  <= (setup & ~PWRITE) ? rd_data : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   wire [15:0] mode_w = (mode_r & ~lm) | (PWDATA[15:0] & lm);
   wire [15:0] per_w  = (16'(period_r) & ~lm) | (PWDATA[15:0] & lm);

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_r   <= `TIC_MODE_RST;
         period_r <= CNT_W'(`TIC_PERIOD_RST);
         oe_r     <= 1'b0;
         nfen_r   <= 1'b0;
      end else begin
         if (wr & sel_mode) begin
            mode_r <= mode_w & MODE_M;
         end
         if (wr & sel_per) begin
            period_r <= CNT_W'(per_w);
         end
         if (wr & sel_oe & PSTRB[0]) begin
            oe_r <= PWDATA[`TIC_FLAG_BIT];
         end
         if (wr & sel_nf & PSTRB[0]) begin
            nfen_r <= PWDATA[`TIC_FLAG_BIT];
         end
      end
   end

   // ----------------------------------------
   // interval counter
   // ----------------------------------------
   localparam int HALF = CNT_W / 2;
   // split mode uses only the lower half of the period
   wire [CNT_W-1:0] reload = split ?
      CNT_W'(period_r[HALF-1:0]) : period_r;
   wire tick = ccs ? edge_r : fmck;
   wire at_zero = (cnt_r == '0);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      evt       = 1'b0;
      if (stop_wr) begin
         state_nxt = TIC_IDLE;
      end else if (start_wr & soft_st) begin
         state_nxt = TIC_LOAD;
      end else begin
         case (state_r)
            TIC_LOAD: begin
               if (tick & interval) begin
                  cnt_nxt   = reload;
                  evt       = md0;
                  state_nxt = TIC_RUN;
               end
            end
            TIC_RUN: begin
               if (tick & interval) begin
                  if (at_zero) begin
                     cnt_nxt = reload;
                     evt     = 1'b1;
                  end else begin
                     cnt_nxt = cnt_r - 1'b1;
                  end
               end
            end
            default: begin
               state_nxt = state_r;
            end
         endcase
      end
   end

   // counting toggles only when enabled; a software level write
   // while enabled is dropped so the timer waveform is undisturbed
   always_comb begin
      out_nxt = out_r;
      if (evt & oe_r) begin
         out_nxt = ~out_r;
      end else if (lvl_wr & ~oe_r) begin
         out_nxt = PWDATA[`TIC_FLAG_BIT];
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_r <= TIC_IDLE;
         cnt_r   <= CNT_W'(`TIC_COUNT_RST);
         out_r   <= 1'b0;
         irq_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         out_r   <= out_nxt;
         irq_r   <= evt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign PRDATA            = prdata_r;
   assign PREADY            = pready_r;
   assign PSLVERR           = pslverr_r;
   assign TIMER_OUTPUT_PIN  = out_r;
   assign CHANNEL_INTERRUPT = irq_r;
   assign INPUT_EDGE        = edge_r;

endmodule

/* File: logic/tic_cfg.svh */
`ifndef TIC_CFG_SVH
`define TIC_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TIC_OFS_MODE   8'h00
`define TIC_OFS_PERIOD 8'h04
`define TIC_OFS_COUNT  8'h08
`define TIC_OFS_START  8'h0C
`define TIC_OFS_OUTLVL 8'h10
`define TIC_OFS_OUTEN  8'h14
`define TIC_OFS_NFEN   8'h18

// ----------------------------------------
// channel mode register fields
// ----------------------------------------
`define TIC_MODE_CKS_HI 15
`define TIC_MODE_CKS_LO 14
`define TIC_MODE_CCS    12
`define TIC_MODE_SPLIT  11
`define TIC_MODE_STS_HI 10
`define TIC_MODE_STS_LO 8
`define TIC_MODE_CIS_HI 7
`define TIC_MODE_CIS_LO 6
`define TIC_MODE_OPM_HI 3
`define TIC_MODE_OPM_LO 1
`define TIC_MODE_MD0    0
`define TIC_MODE_WMASK  16'hDFCF
`define TIC_MODE_RST    16'h0000

// ----------------------------------------
// other fields and reset values
// ----------------------------------------
`define TIC_START_BIT  0
`define TIC_STOP_BIT   1
`define TIC_FLAG_BIT   0
`define TIC_PERIOD_RST 16'h0000
`define TIC_COUNT_RST  16'h0000

`endif

/* File: logic/tic_pkg.sv */
package tic_pkg;

   // counter sequencer, gray coded along idle -> load -> run
   typedef enum logic [1:0] {
      TIC_IDLE = 2'b00,
      TIC_LOAD = 2'b01,
      TIC_RUN  = 2'b11
   } tic_state_t;

   // operating clock select codes
   typedef enum logic [1:0] {
      TIC_CK0 = 2'b00,
      TIC_CK2 = 2'b01,
      TIC_CK1 = 2'b10,
      TIC_CK3 = 2'b11
   } tic_cks_t;

   // input edge select codes
   typedef enum logic [1:0] {
      TIC_EDGE_FALL  = 2'b00,
      TIC_EDGE_RISE  = 2'b01,
      TIC_EDGE_BOTH  = 2'b10,
      TIC_EDGE_BOTHX = 2'b11
   } tic_edge_t;

   typedef enum logic [2:0] {
      TIC_OPM_INTERVAL = 3'b000
   } tic_opm_t;

   typedef enum logic [2:0] {
      TIC_STS_SOFT = 3'b000
   } tic_sts_t;

endpackage

/* File: tb/tic_pin_src.sv */
`timescale 1ns/1ps
module tic_pin_src (
   // clock
   input wire logic       clk,
   // pulse request, length in cycles
   input wire logic       go,
   input wire logic [1:0] width,
   // pin
   output logic           pin
);
   logic [1:0] left_r = 2'h0;
   // moves just after edges: the pin is synchronous to the channel clock
   always @(posedge clk) begin
      if (go) left_r <= width;
      else if (left_r != 2'h0) left_r <= left_r - 2'h1;
   end
   assign pin = (left_r != 2'h0);
endmodule

/* File: tb/tic_channel_assertions.sv */
`timescale 1ns/1ps
module tic_channel_assertions #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic              SYS_CLK,
   input wire logic              RST_N,
   // apb
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic              PSEL,
   input wire logic              PENABLE,
   input wire logic              PWRITE,
   input wire logic [31:0]       PWDATA,
   input wire logic [3:0]        PSTRB,
   input wire logic [31:0]       PRDATA,
   input wire logic              PREADY,
   input wire logic              PSLVERR,
   // timer
   input wire logic              TIMER_OUTPUT_PIN,
   input wire logic              CHANNEL_INTERRUPT
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   // ----
   // shadows
   // ----
   logic wr;
   logic en_r;
   logic nz_r;
   assign wr = PSEL && PENABLE && PREADY && PWRITE;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         en_r <= 1'h0;
         nz_r <= 1'h0;
      end else if (wr && PSTRB[0]) begin
         if (PADDR[7:0] == 8'h14) en_r <= PWDATA[0];
         if (PADDR[7:0] == 8'h04) nz_r <= |PWDATA[15:0];
      end
   end
   // ----
   // properties
   // ----
   sequence s_setup; PSEL && !PENABLE; endsequence
   sequence s_access; PSEL && PENABLE && PREADY; endsequence
   a_ready_next: assert property (s_setup |=> s_access)
      else $error("no ready after setup");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held");
   a_err_map: assert property (PREADY |-> PSLVERR ==
      (PADDR[7:0] > 8'h18 || PADDR[1:0] != 2'h0))
      else $error("wrong slave error");
   a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
      else $error("read data outside answer");
   // period 0 legally fires every tick
   a_irq_single: assert property (
      CHANNEL_INTERRUPT && nz_r |=> !CHANNEL_INTERRUPT)
      else $error("interrupt longer than a cycle");
   a_irq_toggle: assert property (
      CHANNEL_INTERRUPT && $past(en_r) |-> $changed(TIMER_OUTPUT_PIN))
      else $error("no toggle on interrupt");
   a_out_cause: assert property (
      $changed(TIMER_OUTPUT_PIN) |-> ($past(en_r) ? CHANNEL_INTERRUPT
         : $past(wr && PADDR[7:0] == 8'h10)))
      else $error("output changed without cause");
   a_lvl_drive: assert property (
      wr && PADDR[7:0] == 8'h10 && PSTRB[0] && !en_r
      |=> TIMER_OUTPUT_PIN == $past(PWDATA[0]))
      else $error("output level not driven");
endmodule
bind tic_channel tic_channel_assertions #(.ADDR_W(ADDR_W)) u_chk (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .PADDR(PADDR), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PSTRB(PSTRB),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN),
   .CHANNEL_INTERRUPT(CHANNEL_INTERRUPT));

/* File: tb/tb_tic_channel.sv */
`timescale 1ns/1ps
module tb_tic_channel;
   import tic_pkg::*;
   typedef struct packed {
      logic [7:0]  a;
      logic [15:0] wd;
      logic [15:0] ex;
      logic        er;
   } tic_row_t;
   tic_row_t rows [7] = '{'{8'h00, 16'hFFFF, 16'h97CF, 1'h0},
      '{8'h04, 16'h1234, 16'h1234, 1'h0}, '{8'h08, 16'hFFFF, 16'h0, 1'h0},
      '{8'h10, 16'h1, 16'h1, 1'h0}, '{8'h14, 16'h1, 16'h1, 1'h0},
      '{8'h18, 16'h1, 16'h1, 1'h0}, '{8'h1C, 16'hFFFF, 16'h0, 1'h1}};
   logic        SYS_CLK = 1'h0;
   logic        RST_N = 1'h0;
   logic [7:0]  paddr = 8'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  ck_en = 4'hF;
   logic        slow = 1'h0;
   logic        go = 1'h0;
   logic [1:0]  width = 2'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready, pslverr, pin, tout, irq, iedge, er, lv;
   int          n_errors = 0;
   int          tests_run = 0;
   int          n_edge = 0;
   int          ne = 0;
   int          cyc = 0;
   int          t0, t1, t2, t3;
   tic_channel #(.CHANNEL(0)) uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
      .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PWDATA(pwdata), .PSTRB(4'h3), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .PRESCALER_CLK_EN(ck_en), .TIMER_INPUT_PIN(pin),
      .TIMER_OUTPUT_PIN(tout), .CHANNEL_INTERRUPT(irq), .INPUT_EDGE(iedge));
   tic_pin_src u_src (.clk(SYS_CLK), .go(go), .width(width), .pin(pin));
   initial forever #25 SYS_CLK = ~SYS_CLK;
   // slow mode: clock 1 ticks every second cycle, clock 0 every cycle
   always @(posedge SYS_CLK) begin
      ck_en <= slow ? {2'h3, ~ck_en[1], 1'h1} : 4'hF;
      cyc <= cyc + 1;
      if (iedge === 1'h1) n_edge <= n_edge + 1;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end
   // ----
   // tasks
   // ----
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input int d);
      @(posedge SYS_CLK);
      psel <= 1'h1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge SYS_CLK);
      penable <= 1'h1;
      do @(posedge SYS_CLK); while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wait_irq(output int t);
      do @(posedge SYS_CLK); while (irq !== 1'h1);
      t = cyc;
   endtask
   task automatic glitch(input logic [1:0] w, output int n);
      int base;
      base = n_edge;
      @(posedge SYS_CLK);
      go <= 1'h1;
      width <= w;
      @(posedge SYS_CLK);
      go <= 1'h0;
      repeat (12) @(posedge SYS_CLK);
      n = n_edge - base;
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ----
   // sequence
   // ----
   initial begin
      repeat (4) @(posedge SYS_CLK);
      RST_N <= 1'h1;
      foreach (rows[i]) begin
         apb(rows[i].a, 1'h0, 0);
         chk("reset", rd, 32'h0);
         apb(rows[i].a, 1'h1, rows[i].wd);
         apb(rows[i].a, 1'h0, 0);
         chk("readback", rd, {16'h0, rows[i].ex});
         chk("slverr", er, rows[i].er);
      end
      apb(8'h14, 1'h1, 0);
      apb(8'h18, 1'h1, 0);
      apb(8'h10, 1'h1, 0);
      apb(8'h04, 1'h1, 2);
      apb(8'h00, 1'h1, 1);
      apb(8'h14, 1'h1, 1);
      apb(8'h0C, 1'h1, 1);
      t0 = cyc;
      wait_irq(t1);
      chk("start toggle", tout, 1);
      wait_irq(t2);
      chk("gap", t2 - t1, 3);
      apb(8'h0C, 1'h0, 0);
      chk("status", rd, 1);
      apb(8'h0C, 1'h1, 2);
      apb(8'h00, 1'h1, 0);
      apb(8'h0C, 1'h1, 1);
      t2 = cyc;
      wait_irq(t3);
      chk("no start irq", (t3 - t2) - (t1 - t0), 3);
      apb(8'h0C, 1'h1, 2);
      apb(8'h04, 1'h1, 8);
      apb(8'h00, 1'h1, 1);
      apb(8'h0C, 1'h1, 1);
      wait_irq(t0);
      apb(8'h04, 1'h1, 4);
      wait_irq(t1);
      wait_irq(t2);
      chk("old period", t1 - t0, 9);
      chk("new period", t2 - t1, 5);
      lv = tout;
      apb(8'h10, 1'h1, {31'h0, ~lv});
      // the write would land at the answer edge: look one cycle later
      @(posedge SYS_CLK);
      chk("level locked", tout, lv);
      apb(8'h14, 1'h1, 0);
      lv = tout;
      wait_irq(t0);
      chk("hold", tout, lv);
      wait_irq(t1);
      chk("hold", tout, lv);
      apb(8'h0C, 1'h1, 2);
      apb(8'h14, 1'h1, 1);
      apb(8'h04, 1'h1, 2);
      apb(8'h00, 1'h1, 32'h8001);
      slow <= 1'h1;
      apb(8'h0C, 1'h1, 1);
      wait_irq(t0);
      wait_irq(t1);
      chk("clock 1", t1 - t0, 6);
      slow <= 1'h0;
      apb(8'h0C, 1'h1, 2);
      apb(8'h00, 1'h1, 0);
      glitch(2'h3, ne);
      chk("unused", ne, 0);
      // a two-cycle pulse meets one slow operating-clock sample only
      slow <= 1'h1;
      apb(8'h00, 1'h1, 32'h8100);
      repeat (4) @(posedge SYS_CLK);
      glitch(2'h2, ne);
      chk("raw", ne, 1);
      apb(8'h00, 1'h1, 0);
      apb(8'h18, 1'h1, 1);
      apb(8'h00, 1'h1, 32'h8100);
      repeat (8) @(posedge SYS_CLK);
      glitch(2'h2, ne);
      chk("spike", ne, 0);
      slow <= 1'h0;
      apb(8'h00, 1'h1, 32'h0100);
      glitch(2'h3, ne);
      chk("pulse", ne, 1);
      apb(8'h00, 1'h1, 1);
      apb(8'h0C, 1'h1, 1);
      repeat (5) @(posedge SYS_CLK);
      RST_N <= 1'h0;
      repeat (2) @(posedge SYS_CLK);
      chk("in reset", {irq, tout, pready}, 0);
      RST_N <= 1'h1;
      apb(8'h00, 1'h0, 0);
      chk("mode reset", rd, 0);
      conclude();
   end
endmodule
